// >>> dv/o5cp_top_tb_top.sv
// self-checking testbench for the output5 clock path control
`timescale 1ns/1ps
module o5cp_top_tb_top;
  logic       clock    = 1'b0;
  logic       reset    = 1'b1;
  logic [7:0] addr     = 8'h00;
  logic [7:0] wdata    = 8'h00;
  logic       write    = 1'b0;
  logic       read     = 1'b0;
  logic [3:0] srcs     = 4'h0;
  logic [7:0] rdata;
  logic       out_clk;
  logic       pd;
  logic       int_mode;
  logic       pll_sel;
  logic [1:0] drv;
  logic [3:0] ma;
  logic [7:0] got;
  logic [7:0] d;
  logic [3:0] s;
  logic [15:0] hist    = 16'h0000;
  int         errors   = 0;
  int         checks   = 0;

  o5cp_top o5cp_top_inst (
    .I_CLOCK(clock), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WRITE(write), .I_READ(read), .I_CRYSTAL_CLK(srcs[3]), .I_REFIN_CLK(srcs[2]),
    .I_FIRST_PLL_CLK(srcs[1]), .I_SECOND_PLL_CLK(srcs[0]), .O_RDATA(rdata),
    .O_OUT5_CLK(out_clk), .O_OUT5_POWER_DOWN(pd), .O_DIVIDER5_INTEGER_MODE(int_mode),
    .O_DIVIDER5_PLL_SELECT(pll_sel), .O_OUT5_DRIVE_STRENGTH(drv), .O_OUT5_DRIVE_MA(ma)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  // expected output5 level from register value and source levels
  function automatic logic exp_clk(input logic [7:0] v, input logic [3:0] s);
    logic c;
    case (v[3:2])
      2'h0: c = s[3];
      2'h1: c = s[2];
      2'h3: c = v[5] ? s[0] : s[1];
      default: c = 1'b0;
    endcase
    return v[7] ? 1'b0 : (c ^ v[4]);
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    write <= 1'b1;
    addr  <= a;
    wdata <= v;
    srcs  <= 4'($urandom);
    @(posedge clock);
    write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    read <= 1'b1;
    addr <= a;
    @(posedge clock);
    read <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic check_all(input logic [7:0] v);
    wr(8'h15, v);
    rd(8'h15, got);
    chk(got, v);
    chk({7'h00, pd}, {7'h00, v[7]});
    chk({7'h00, int_mode}, {7'h00, v[6]});
    chk({7'h00, pll_sel}, {7'h00, v[5]});
    chk({6'h00, drv}, {6'h00, v[1:0]});
    chk({4'h0, ma}, 8'h02 + {5'h00, v[1:0], 1'b0});
    chk({7'h00, out_clk}, {7'h00, exp_clk(v, srcs)});
  endtask

  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    results;
  end

  initial begin
    void'($urandom(32'h585d));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd(8'h15, got);
    chk(got, 8'h00);
    chk({4'h0, ma}, 8'h02);
    for (int i = 0; i < 60; i++) begin
      // no delay offset exists here, so integer mode may be set freely
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      if (d[3:2] == 2'h2) d[2] = 1'b1;
      check_all(d);
    end
    // one setting held while the sources run; output trails the pins by three edges
    d = 8'h3C;
    wr(8'h15, d);
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      s = 4'($urandom);
      srcs <= s;
      hist = {hist[11:0], s};
      #1;
      if (i >= 3) chk({7'h00, out_clk}, {7'h00, exp_clk(d, hist[15:12])});
    end
    wr(8'h14, ~d);
    rd(8'h14, got);
    chk(got, 8'h00);
    rd(8'h15, got);
    chk(got, d);
    results;
  end
endmodule // o5cp_top_tb_top

// >>> rtl/o5cp_clock_mux.sv
// clock source selection and inversion for output5
`timescale 1ns/1ps
module o5cp_clock_mux (
  input  wire logic       i_crystal_clk,
  input  wire logic       i_refin_clk,
  input  wire logic       i_divider_clk,
  input  wire logic [1:0] i_source,
  input  wire logic       i_invert,
  input  wire logic       i_power_down,
  output logic            o_clk
);
  logic sel;
  always_comb begin
    unique case (i_source)
      o5cp_pkg::O5CP_SRC_CRYSTAL: sel = i_crystal_clk;
      o5cp_pkg::O5CP_SRC_REFIN:   sel = i_refin_clk;
      o5cp_pkg::O5CP_SRC_DIVIDER: sel = i_divider_clk;
      default:                    sel = 1'b0;
    endcase
  end
  // powered down driver holds low regardless of inversion
  assign o_clk = i_power_down ? 1'b0 : (sel ^ i_invert);
endmodule // o5cp_clock_mux

// >>> rtl/o5cp_pkg.sv
// package with register layout and encodings for the output5 clock path control
package o5cp_pkg;
  localparam logic [7:0] O5CP_ADDR_CONTROL   = 8'h15;
  localparam logic [7:0] O5CP_CONTROL_RESET  = 8'h00;
  localparam int         O5CP_BIT_POWER_DOWN = 7;
  localparam int         O5CP_BIT_INT_MODE   = 6;
  localparam int         O5CP_BIT_PLL_SEL    = 5;
  localparam int         O5CP_BIT_INVERT     = 4;
  localparam int         O5CP_SRC_HI         = 3;
  localparam int         O5CP_SRC_LO         = 2;
  localparam int         O5CP_DRV_HI         = 1;
  localparam int         O5CP_DRV_LO         = 0;
  localparam logic [1:0] O5CP_SRC_CRYSTAL    = 2'h0;
  localparam logic [1:0] O5CP_SRC_REFIN      = 2'h1;
  localparam logic [1:0] O5CP_SRC_RESERVED   = 2'h2;
  localparam logic [1:0] O5CP_SRC_DIVIDER    = 2'h3;
  localparam logic [3:0] O5CP_MA_2           = 4'h2;
  localparam logic [3:0] O5CP_MA_4           = 4'h4;
  localparam logic [3:0] O5CP_MA_6           = 4'h6;
  localparam logic [3:0] O5CP_MA_8           = 4'h8;
endpackage

// >>> rtl/o5cp_top.sv
// output5 clock path control register and source selection
`timescale 1ns/1ps
module o5cp_top (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RESET,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WRITE,
  input  wire logic       I_READ,
  input  wire logic       I_CRYSTAL_CLK,
  input  wire logic       I_REFIN_CLK,
  input  wire logic       I_FIRST_PLL_CLK,
  input  wire logic       I_SECOND_PLL_CLK,
  output logic [7:0]      O_RDATA,
  output logic            O_OUT5_CLK,
  output logic            O_OUT5_POWER_DOWN,
  output logic            O_DIVIDER5_INTEGER_MODE,
  output logic            O_DIVIDER5_PLL_SELECT,
  output logic [1:0]      O_OUT5_DRIVE_STRENGTH,
  output logic [3:0]      O_OUT5_DRIVE_MA
);
  logic [7:0] control_r;
  logic [3:0] src_pins;
  logic [3:0] src_sync;
  logic       crystal_sync;
  logic       refin_sync;
  logic       first_pll_sync;
  logic       second_pll_sync;
  logic       divider_clk;
  logic       mux_clk;
  logic       hit;

  assign hit = (I_ADDR == o5cp_pkg::O5CP_ADDR_CONTROL);

  // source pins run on their own clocks; two flops each before any logic reads them
  assign src_pins = {I_CRYSTAL_CLK, I_REFIN_CLK, I_FIRST_PLL_CLK, I_SECOND_PLL_CLK};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic meta_r;
    logic sync_r;
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
        meta_r <= 1'h0;
        sync_r <= 1'h0;
      end else begin
        meta_r <= src_pins[g];
        sync_r <= meta_r;
      end
    end
    assign src_sync[g] = sync_r;
  end

  assign crystal_sync    = src_sync[3];
  assign refin_sync      = src_sync[2];
  assign first_pll_sync  = src_sync[1];
  assign second_pll_sync = src_sync[0];

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      control_r <= o5cp_pkg::O5CP_CONTROL_RESET;
    end else if (I_WRITE && hit) begin
      control_r <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else if (I_READ && hit) begin
      O_RDATA <= control_r;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_OUT5_POWER_DOWN       <= 1'b0;
      O_DIVIDER5_INTEGER_MODE <= 1'b0;
      O_DIVIDER5_PLL_SELECT   <= 1'b0;
      O_OUT5_DRIVE_STRENGTH   <= 2'h0;
    end else begin
      O_OUT5_POWER_DOWN       <= control_r[o5cp_pkg::O5CP_BIT_POWER_DOWN];
      O_DIVIDER5_INTEGER_MODE <= control_r[o5cp_pkg::O5CP_BIT_INT_MODE];
      O_DIVIDER5_PLL_SELECT   <= control_r[o5cp_pkg::O5CP_BIT_PLL_SEL];
      O_OUT5_DRIVE_STRENGTH   <= control_r[o5cp_pkg::O5CP_DRV_HI:o5cp_pkg::O5CP_DRV_LO];
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_OUT5_DRIVE_MA <= o5cp_pkg::O5CP_MA_2;
    end else begin
      unique case (control_r[o5cp_pkg::O5CP_DRV_HI:o5cp_pkg::O5CP_DRV_LO])
        2'h0: O_OUT5_DRIVE_MA <= o5cp_pkg::O5CP_MA_2;
        2'h1: O_OUT5_DRIVE_MA <= o5cp_pkg::O5CP_MA_4;
        2'h2: O_OUT5_DRIVE_MA <= o5cp_pkg::O5CP_MA_6;
        2'h3: O_OUT5_DRIVE_MA <= o5cp_pkg::O5CP_MA_8;
      endcase
    end
  end

  // divider input choice; the divider itself lives outside this block
  assign divider_clk = control_r[o5cp_pkg::O5CP_BIT_PLL_SEL] ? second_pll_sync
                                                            : first_pll_sync;

  o5cp_clock_mux o5cp_clock_mux_inst (
    .i_crystal_clk (crystal_sync),
    .i_refin_clk   (refin_sync),
    .i_divider_clk (divider_clk),
    .i_source      (control_r[o5cp_pkg::O5CP_SRC_HI:o5cp_pkg::O5CP_SRC_LO]),
    .i_invert      (control_r[o5cp_pkg::O5CP_BIT_INVERT]),
    .i_power_down  (control_r[o5cp_pkg::O5CP_BIT_POWER_DOWN]),
    .o_clk         (mux_clk)
  );

  // sampled output; a clock faster than I_CLOCK/2 will alias here
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_OUT5_CLK <= 1'b0;
    end else begin
      O_OUT5_CLK <= mux_clk;
    end
  end

  property p_readback;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (I_READ && hit && !I_WRITE) |=> (O_RDATA == $past(control_r));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_write_store;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (I_WRITE && hit) |=> (control_r == $past(I_WDATA));
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");

  property p_power_down;
    @(posedge I_CLOCK) disable iff (I_RESET)
      control_r[7] |=> (O_OUT5_POWER_DOWN && !O_OUT5_CLK);
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down ignored");

  property p_int_mode;
    @(posedge I_CLOCK) disable iff (I_RESET)
      ##1 (O_DIVIDER5_INTEGER_MODE == $past(control_r[6]));
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("integer mode wrong");

  property p_pll_sel;
    @(posedge I_CLOCK) disable iff (I_RESET)
      ##1 (O_DIVIDER5_PLL_SELECT == $past(control_r[5]));
  endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("pll select wrong");

  property p_crystal;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (control_r[7] == 1'b0 && control_r[3:2] == 2'h0)
        |=> (O_OUT5_CLK == ($past(crystal_sync) ^ $past(control_r[4])));
  endproperty
  a_crystal: assert property (p_crystal) else $error("crystal path wrong");

  property p_refin;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (control_r[7] == 1'b0 && control_r[3:2] == 2'h1)
        |=> (O_OUT5_CLK == ($past(refin_sync) ^ $past(control_r[4])));
  endproperty
  a_refin: assert property (p_refin) else $error("reference path wrong");

  property p_divider;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (control_r[7] == 1'b0 && control_r[3:2] == 2'h3)
        |=> (O_OUT5_CLK == ($past(divider_clk) ^ $past(control_r[4])));
  endproperty
  a_divider: assert property (p_divider) else $error("divider path wrong");

  property p_drive;
    @(posedge I_CLOCK) disable iff (I_RESET)
      ##1 (O_OUT5_DRIVE_MA == {1'b0, $past(control_r[1:0]), 1'b0} + 4'h2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive current wrong");

  property p_first_pll;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (!control_r[7] && !control_r[5] && control_r[3:2] == 2'h3)
        |=> (O_OUT5_CLK == ($past(first_pll_sync) ^ $past(control_r[4])));
  endproperty
  a_first_pll: assert property (p_first_pll) else $error("first pll path wrong");

  property p_second_pll;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (!control_r[7] && control_r[5] && control_r[3:2] == 2'h3)
        |=> (O_OUT5_CLK == ($past(second_pll_sync) ^ $past(control_r[4])));
  endproperty
  a_second_pll: assert property (p_second_pll) else $error("second pll path wrong");

  property p_rdata_idle;
    @(posedge I_CLOCK) disable iff (I_RESET)
      !(I_READ && hit) |=> (O_RDATA == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_drive_code;
    @(posedge I_CLOCK) disable iff (I_RESET)
      ##1 (O_OUT5_DRIVE_STRENGTH == $past(control_r[1:0]));
  endproperty
  a_drive_code: assert property (p_drive_code) else $error("drive code wrong");

  property p_sync_chain;
    @(posedge I_CLOCK) disable iff (I_RESET)
      ##2 (src_sync == $past(src_pins, 2));
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("source sync lag wrong");

  property p_unmapped_write;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (I_WRITE && !hit) |=> $stable(control_r);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write stored");

  property p_read_no_effect;
    @(posedge I_CLOCK) disable iff (I_RESET)
      (I_READ && !I_WRITE) |=> $stable(control_r);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("read changed register");
endmodule // o5cp_top
